/* bench/sicr_asserts.sv */
// port checker for the interface configuration register
`timescale 1ns/1ps
module sicr_asserts
  import sicr_pkg::*;
(
  input logic ref_clk,
  input logic nrst,
  input logic sck,
  input logic cs_n,
  input logic [3:0] io_in,
  input logic [3:0] io_out,
  input logic [3:0] io_oe,
  input logic quad_data_en,
  input sicr_mode_t proto_mode,
  input logic io3_reset_n,
  input logic wide_io_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_reset_spi: assert property ($rose(nrst) |-> proto_mode == SICR_SPI)
    else $error("mode not single after reset");
  a_spi_lanes: assert property (proto_mode == SICR_SPI |->
    io_oe inside {4'h0, 4'h2}) else $error("single-line lanes wrong");
  a_dual_lanes: assert property (proto_mode == SICR_DUAL |->
    io_oe inside {4'h0, 4'h3}) else $error("dual lanes wrong");
  a_quad_lanes: assert property (proto_mode == SICR_QUAD |->
    io_oe inside {4'h0, 4'hf}) else $error("quad lanes wrong");
  a_quad_wide: assert property (proto_mode == SICR_QUAD |->
    wide_io_data) else $error("quad protocol without wide data");
  a_idle_release: assert property (cs_n [*8] |=> io_oe == 4'h0)
    else $error("device drives while deselected");
  a_drive_frame: assert property ($rose(|io_oe) |-> !cs_n)
    else $error("drive starts outside a frame");
  a_io3_idle: assert property (io_in[3] [*8] |-> io3_reset_n)
    else $error("reset out with io3 high");
  a_rst_cs_high: assert property (!io3_reset_n |-> $past(cs_n, 4))
    else $error("io3 reset while selected");
endmodule

bind sicr_top sicr_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .quad_data_en(quad_data_en), .proto_mode(proto_mode),
  .io3_reset_n(io3_reset_n), .wide_io_data(wide_io_data));

/* bench/sicr_host.sv */
// host controller model on the register link
`timescale 1ns/1ps
module sicr_host
  import sicr_pkg::*;
(
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_drv,
  input logic [3:0] io
);
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    io_drv = 4'hf;
  end
  // mode 0: data set while sck low, msb first; unused lanes held high while the host sends, inverted every cycle of the read phase
  task automatic frame(input int w, input logic [7:0] op,
    input logic [23:0] ad, input bit rd, input logic [7:0] wd,
    output logic [7:0] rv);
    logic [39:0] sh;
    int n;
    sh = {op, ad, wd};
    n = (op == SICR_OP_READ_CFG) ? 8 : (rd ? 32 : 40);
    rv = 8'h00;
    cs_n = 1'h0;
    for (int i = 0; i < n; i += w) begin
      io_drv = (w == 4) ? sh[39-i -: 4] :
        (w == 2) ? {2'h3, sh[39-i -: 2]} : {3'h7, sh[39-i]};
      #40 sck = 1'h1;
      #40 sck = 1'h0;
    end
    for (int i = 0; rd && i < 8; i += w) begin
      io_drv = ~io_drv; // released lanes never keep a stale level
      #40 sck = 1'h1;
      rv = (w == 4) ? {rv[3:0], io} :
        (w == 2) ? {rv[5:0], io[1:0]} : {rv[6:0], io[1]};
      #40 sck = 1'h0;
    end
    #40 cs_n = 1'h1;
    io_drv = 4'hf;
    #200;
  endtask
  task automatic hold_io(input logic [3:0] v);
    io_drv = v;
  endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the interface configuration register
`timescale 1ns/1ps
module testbench
  import sicr_pkg::*;
;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic quad_data_en = 1'h0;
  logic sck;
  logic cs_n;
  logic [3:0] io_drv;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] io_in;
  sicr_mode_t proto_mode;
  logic io3_reset_n;
  logic wide_io_data;
  logic [7:0] rv;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  assign io_in = (io_oe & io_out) | (~io_oe & io_drv);
  always #5 ref_clk = ~ref_clk;
  sicr_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .sck(sck), .cs_n(cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .quad_data_en(quad_data_en), .proto_mode(proto_mode),
    .io3_reset_n(io3_reset_n), .wide_io_data(wide_io_data));
  sicr_host u_host (.sck(sck), .cs_n(cs_n), .io_drv(io_drv), .io(io_in));
  task automatic chk(input string nm, input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic rd(input int w, input logic [7:0] op, input logic [23:0] a);
    u_host.frame(w, op, a, 1'b1, 8'h00, rv);
  endtask
  task automatic wr(input int w, input logic [23:0] a, input logic [7:0] d);
    u_host.frame(w, SICR_OP_WRITE_ANY, a, 1'b0, d, rv);
  endtask
  // about 3.4k cycles of frames expected
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk);
    nrst = 1'h1;
    repeat (10) @(negedge ref_clk);
    chk("mode", proto_mode, SICR_SPI);
    u_host.hold_io(4'h7);
    repeat (10) @(negedge ref_clk);
    chk("io3 off", io3_reset_n, 8'h01);
    u_host.hold_io(4'hf);
    repeat (10) @(negedge ref_clk);
    rd(1, SICR_OP_READ_CFG, 24'h00_0000);
    chk("cfg", rv, SICR_FACTORY);
    rd(1, SICR_OP_READ_ANY, SICR_NV_ADDR);
    chk("nv", rv, SICR_FACTORY);
    wr(1, SICR_VOL_ADDR, 8'hff);
    rd(1, SICR_OP_READ_ANY, SICR_VOL_ADDR);
    chk("vol", rv, 8'h70);
    rd(1, SICR_OP_READ_ANY, SICR_NV_ADDR);
    chk("nv", rv, 8'h00);
    chk("mode", proto_mode, SICR_SPI);
    chk("wide", wide_io_data, 8'h00);
    quad_data_en = 1'h1;
    @(negedge ref_clk);
    chk("wide", wide_io_data, 8'h01);
    quad_data_en = 1'h0;
    rd(1, SICR_OP_READ_ANY, 24'h00_0005);
    chk("unmapped", rv, 8'h00);
    wr(1, SICR_VOL_ADDR, 8'h40);
    chk("mode", proto_mode, SICR_QUAD);
    chk("wide", wide_io_data, 8'h01);
    rd(4, SICR_OP_READ_CFG, 24'h00_0000);
    chk("cfg", rv, 8'h40);
    wr(4, SICR_VOL_ADDR, 8'h10);
    chk("mode", proto_mode, SICR_DUAL);
    rd(2, SICR_OP_READ_ANY, SICR_VOL_ADDR);
    chk("vol", rv, 8'h10);
    wr(2, SICR_NV_ADDR, 8'h60);
    rd(2, SICR_OP_READ_ANY, SICR_NV_ADDR);
    chk("nv", rv, 8'h60);
    chk("mode", proto_mode, SICR_DUAL);
    wr(2, SICR_VOL_ADDR, 8'h20);
    chk("mode", proto_mode, SICR_SPI);
    // io3 low while deselected resets and reloads the working copy
    u_host.hold_io(4'h7);
    repeat (10) @(negedge ref_clk);
    chk("io3 rst", io3_reset_n, 8'h00);
    chk("mode", proto_mode, SICR_QUAD);
    u_host.hold_io(4'hf);
    repeat (10) @(negedge ref_clk);
    rd(4, SICR_OP_READ_ANY, SICR_VOL_ADDR);
    chk("vol", rv, 8'h60);
    nrst = 1'h0;
    repeat (3) @(negedge ref_clk);
    nrst = 1'h1;
    repeat (10) @(negedge ref_clk);
    rd(1, SICR_OP_READ_CFG, 24'h00_0000);
    chk("cfg", rv, SICR_FACTORY);
    report_and_stop();
  end
endmodule

/* design/sicr_pkg.sv */
// shared constants and types for the interface configuration register
package sicr_pkg;

  // register addresses on the link
  localparam logic [23:0] SICR_NV_ADDR = 24'h00_0003;
  localparam logic [23:0] SICR_VOL_ADDR = 24'h07_0003;

  // values after reset and writable field mask
  localparam logic [7:0] SICR_FACTORY = 8'h00;
  localparam logic [7:0] SICR_WR_MASK = 8'h70;

  // field positions
  localparam int SICR_QUAD_BIT = 6;
  localparam int SICR_IO3_ALT_RESET_EN_BIT = 5;
  localparam int SICR_DUAL_BIT = 4;

  // opcodes, values arbitrary
  localparam logic [7:0] SICR_OP_WRITE_ANY = 8'hA1;
  localparam logic [7:0] SICR_OP_READ_ANY = 8'hA2;
  localparam logic [7:0] SICR_OP_READ_CFG = 8'hA3;

  // bit counts of the link phases
  localparam logic [5:0] SICR_CMD_BITS = 6'h08;
  localparam logic [5:0] SICR_ADDR_BITS = 6'h18;
  localparam logic [5:0] SICR_DATA_BITS = 6'h08;

  // synchroniser idle values: cs_n high, sck low, io lines high
  localparam logic [5:0] SICR_SYNC_INIT = 6'h2F;
  localparam int SICR_SYNC_W = 6;

  typedef enum logic [1:0] {
    SICR_SPI,
    SICR_DUAL,
    SICR_QUAD
  } sicr_mode_t;

  typedef enum logic [2:0] {
    SICR_ST_CMD,
    SICR_ST_ADDR,
    SICR_ST_WDATA,
    SICR_ST_RDATA,
    SICR_ST_SKIP
  } sicr_state_t;

endpackage

/* design/sicr_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sicr_sync
  import sicr_pkg::*;
#(
  parameter int W = SICR_SYNC_W,
  parameter logic [W-1:0] INIT = SICR_SYNC_INIT
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sicr_sync_t;

  sicr_sync_t s;
  sicr_sync_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // a bit moves only when the second and third stage agree
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.val[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= {INIT, INIT, INIT, INIT};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.val;

endmodule

/* design/sicr_top.sv */
// interface configuration register with its serial command front end
// Functional notes
// R1 - only write-any-register writes it; read-config and read-any read it.
// R2 - write-any at the stored-copy address updates the non-volatile copy.
// R3 - write-any at the volatile address updates only the working copy.
// R4 - read-any at either register address returns the register contents.
// R5 - both copies start with every bit at zero.
// R6 - bit 6 alone selects quad-wide, every phase four bits wide.
// R7 - bit 4 alone selects dual-wide, every phase two bits wide.
// R8 - with both protocol bits clear the single-line protocol is used.
// R9 - bit 5 makes io3 an active-low reset input while chip select is high.
// R10 - bits 7 and 3 to 0 are reserved and always hold zero.
// R11 - the working copy has the three writable fields of the stored copy.
// R12 - with both protocol bits set the device falls back to single-line.
// R13 - reads return the stored value even in that discouraged combination.
// R14 - the quad protocol ignores the separate quad data-width bit.
// R15 - after reset the working copy is loaded from the stored copy.
`timescale 1ns/1ps
module sicr_top
  import sicr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_data_en,
  output sicr_mode_t proto_mode,
  output logic io3_reset_n,
  output logic wide_io_data
);

  typedef struct packed {
    sicr_state_t st;
    sicr_mode_t fmode;
    logic [5:0] cnt;
    logic [23:0] sr;
    logic [23:0] addr;
    logic [7:0] cmd;
    logic [7:0] ob;
    logic [7:0] nv;
    logic [7:0] vol;
    logic load_pend;
    logic sck_d;
    logic rst_n;
    logic [4:0] oe3_hist;
  } sicr_top_t;

  sicr_top_t s;
  sicr_top_t next_s;
  logic [5:0] pins;
  logic sck_f;
  logic cs_f;
  logic [3:0] io_f;
  logic rise;
  logic [5:0] w;
  logic [5:0] cnt_nx;
  logic [23:0] sr_nx;
  sicr_mode_t vol_mode;

  sicr_sync #(
    .W(SICR_SYNC_W),
    .INIT(SICR_SYNC_INIT)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .din({cs_n, sck, io_in}),
    .dout(pins)
  );

  assign cs_f = pins[5];
  assign sck_f = pins[4];
  assign io_f = pins[3:0];

  function automatic sicr_mode_t decode(input logic [7:0] r);
    sicr_mode_t m;
    m = SICR_SPI;
    if (r[SICR_QUAD_BIT] && !r[SICR_DUAL_BIT]) begin
      m = SICR_QUAD; // R6
    end else if (r[SICR_DUAL_BIT] && !r[SICR_QUAD_BIT]) begin
      m = SICR_DUAL; // R7
    end
    // neither or both bits set stays single-line
    return m; // R8 R12
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] r,
                                           input logic [3:0] d,
                                           input sicr_mode_t m);
    logic [23:0] o;
    o = {r[22:0], d[0]};
    unique case (m)
      SICR_SPI: o = {r[22:0], d[0]};
      SICR_DUAL: o = {r[21:0], d[1:0]};
      SICR_QUAD: o = {r[19:0], d[3:0]};
      default: o = {r[22:0], d[0]};
    endcase
    return o;
  endfunction

  function automatic logic [7:0] rotate(input logic [7:0] r,
                                        input sicr_mode_t m);
    logic [7:0] o;
    o = {r[6:0], r[7]};
    unique case (m)
      SICR_SPI: o = {r[6:0], r[7]};
      SICR_DUAL: o = {r[5:0], r[7:6]};
      SICR_QUAD: o = {r[3:0], r[7:4]};
      default: o = {r[6:0], r[7]};
    endcase
    return o;
  endfunction

  // either address returns its own copy
  function automatic logic [7:0] read_sel(input logic [23:0] a,
                                          input logic [7:0] nv,
                                          input logic [7:0] vol);
    logic [7:0] o;
    o = 8'h00;
    if (a == SICR_NV_ADDR) begin
      o = nv; // R4
    end else if (a == SICR_VOL_ADDR) begin
      o = vol; // R4
    end
    return o;
  endfunction

  always_comb begin
    vol_mode = decode(s.vol);
    rise = sck_f && !s.sck_d;
    unique case (s.fmode)
      SICR_SPI: w = 6'h01;
      SICR_DUAL: w = 6'h02;
      SICR_QUAD: w = 6'h04;
      default: w = 6'h01;
    endcase
    cnt_nx = s.cnt + w;
    sr_nx = shift_in(s.sr, io_f, s.fmode);
  end

  always_comb begin
    next_s = s;
    next_s.sck_d = sck_f;
    // own io3 drive lingers until cs is seen high, so it must not reset
    next_s.oe3_hist = {s.oe3_hist[3:0], io_oe[3]};
    next_s.rst_n = !(s.vol[SICR_IO3_ALT_RESET_EN_BIT] && cs_f && !io_f[3] &&
                     s.oe3_hist == 5'h00); // R9
    if (s.load_pend) begin
      next_s.vol = s.nv & SICR_WR_MASK; // R15
      next_s.load_pend = 1'b0;
    end
    // a pin reset reloads the working copy like a power-up; set wins
    if (!s.rst_n) begin
      next_s.load_pend = 1'b1;
    end
    if (cs_f) begin
      // mode changes only take hold at the next frame
      next_s.st = SICR_ST_CMD;
      next_s.cnt = 6'h00;
      next_s.fmode = vol_mode;
    end else if (rise) begin
      next_s.sr = sr_nx;
      next_s.cnt = cnt_nx;
      unique case (s.st)
        SICR_ST_CMD: begin
          if (cnt_nx == SICR_CMD_BITS) begin
            next_s.cnt = 6'h00;
            next_s.cmd = sr_nx[7:0];
            if (sr_nx[7:0] == SICR_OP_WRITE_ANY ||
                sr_nx[7:0] == SICR_OP_READ_ANY) begin
              next_s.st = SICR_ST_ADDR; // R1
            end else if (sr_nx[7:0] == SICR_OP_READ_CFG) begin
              next_s.st = SICR_ST_RDATA; // R1
              next_s.ob = s.vol; // R13
            end else begin
              next_s.st = SICR_ST_SKIP;
            end
          end
        end
        SICR_ST_ADDR: begin
          if (cnt_nx == SICR_ADDR_BITS) begin
            next_s.cnt = 6'h00;
            next_s.addr = sr_nx;
            if (s.cmd == SICR_OP_WRITE_ANY) begin
              next_s.st = SICR_ST_WDATA;
            end else begin
              next_s.st = SICR_ST_RDATA;
              next_s.ob = read_sel(sr_nx, s.nv, s.vol); // R4 R13
            end
          end
        end
        SICR_ST_WDATA: begin
          if (cnt_nx == SICR_DATA_BITS) begin
            next_s.st = SICR_ST_SKIP;
            // reserved bits never store, so they read back zero
            if (s.addr == SICR_NV_ADDR) begin
              next_s.nv = sr_nx[7:0] & SICR_WR_MASK; // R2 R10
            end else if (s.addr == SICR_VOL_ADDR) begin
              next_s.vol = sr_nx[7:0] & SICR_WR_MASK; // R3 R11
            end
          end
        end
        SICR_ST_RDATA: begin
          // long reads repeat the byte
          next_s.ob = rotate(s.ob, s.fmode);
        end
        SICR_ST_SKIP: begin
          next_s.cnt = 6'h00;
        end
        default: begin
          next_s.st = SICR_ST_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s.st <= SICR_ST_CMD;
      s.fmode <= SICR_SPI;
      s.cnt <= 6'h00;
      s.sr <= 24'h00_0000;
      s.addr <= 24'h00_0000;
      s.cmd <= 8'h00;
      s.ob <= 8'h00;
      s.nv <= SICR_FACTORY; // R5
      s.vol <= SICR_FACTORY; // R5
      s.load_pend <= 1'b1;
      s.sck_d <= 1'b0;
      s.rst_n <= 1'b1;
      s.oe3_hist <= 5'h00;
    end else begin
      s <= next_s;
    end
  end

  // output lines follow the frame's width
  always_comb begin
    io_out = 4'h0;
    io_oe = 4'h0;
    if (s.st == SICR_ST_RDATA && !cs_f) begin
      unique case (s.fmode)
        SICR_SPI: begin
          io_out = {2'b00, s.ob[7], 1'b0};
          io_oe = 4'h2;
        end
        SICR_DUAL: begin
          io_out = {2'b00, s.ob[7:6]}; // R7
          io_oe = 4'h3;
        end
        SICR_QUAD: begin
          io_out = s.ob[7:4]; // R6
          io_oe = 4'hF;
        end
        default: begin
          io_out = 4'h0;
          io_oe = 4'h0;
        end
      endcase
    end
  end

  assign proto_mode = vol_mode;
  assign io3_reset_n = s.rst_n;
  assign wide_io_data = (vol_mode == SICR_QUAD) || quad_data_en; // R14

endmodule
